// file: rcw_top.sv
// reset combiner, warm-up sequencer and cause register with axi4-lite access
`timescale 1ns/10ps
`default_nettype none

module rcw_top #(
  parameter int unsigned WARMUP_CYCLES = rcw_pkg::WARMUP_DEFAULT
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  por_n,
  input  wire logic                  shared_port_pin,
  input  wire logic                  serial_mode,
  input  wire rcw_pkg::rcw_factor_t  factors,
  input  wire logic [7:0]            trim_store_data,
  input  wire logic                  trim_store_bad,
  output logic                       trim_store_rd,
  output rcw_pkg::rcw_core_t         core,
  output logic                       vdet_disable,
  output logic                       sys_reset_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  logic                          pin_s1_q;
  logic                          pin_s2_q;
  logic                          por_s1_q;
  logic                          por_s2_q;
  logic [rcw_pkg::FCNT_W-1:0]    low_cnt_q;
  logic                          ext_rst_q;
  logic                          por_rst;
  logic                          hard_rst;
  logic                          factor_rst;
  logic                          any_rst;
  rcw_pkg::rcw_state_t           state_q;
  logic [rcw_pkg::WCNT_W-1:0]    wcnt_q;
  logic                          warm_done;
  logic [7:0]                    trim_q;
  logic [7:0]                    trim_chk_q;
  logic                          trim_corrupt;
  logic [rcw_pkg::NCAUSE-1:0]    cause_q;
  logic                          clear_pend_q;
  logic                          vdet_dis_q;
  logic                          clear_hit;
  logic                          ctrl_wr;
  logic                          aw_q;
  logic                          w_q;
  logic [7:0]                    awaddr_q;
  logic [31:0]                   wdata_q;

  // two-stage synchronisers for pin and power-on reset
  always_ff @(posedge aclk) begin
    pin_s1_q <= shared_port_pin;
    pin_s2_q <= pin_s1_q;
    por_s1_q <= por_n;
    por_s2_q <= por_s1_q;
  end

  assign por_rst = !aresetn || !por_s2_q;

  // pin filter: a low lasting the minimum time asserts the external reset
  always_ff @(posedge aclk) begin
    if (por_rst) begin
      low_cnt_q <= '0;
      ext_rst_q <= 1'b1;
    end else if (pin_s2_q) begin
      low_cnt_q <= '0;
      ext_rst_q <= 1'b0;
    end else if (low_cnt_q >= rcw_pkg::FCNT_W'(rcw_pkg::PIN_LOW_CYCLES - 1)) begin
      ext_rst_q <= 1'b1;
    end else begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  assign hard_rst = por_rst || ext_rst_q;
  assign trim_corrupt = (state_q == rcw_pkg::RCW_RUN) && (trim_q != trim_chk_q);
  assign factor_rst = (state_q == rcw_pkg::RCW_RUN) &&
                      (factors.wdt_ovf || factors.sysclk_dead || factors.lvd1 ||
                       factors.lvd2 || trim_corrupt);
  assign any_rst = hard_rst || factor_rst;
  assign warm_done = wcnt_q == rcw_pkg::WCNT_W'(WARMUP_CYCLES - 1);

  // sequencer
  always_ff @(posedge aclk) begin
    if (any_rst) begin
      state_q <= rcw_pkg::RCW_RESET;
    end else begin
      unique case (state_q)
        rcw_pkg::RCW_RESET: begin
          state_q <= rcw_pkg::RCW_WARMUP;
        end
        rcw_pkg::RCW_WARMUP: begin
          if (warm_done) begin
            state_q <= rcw_pkg::RCW_RUN;
          end
        end
        rcw_pkg::RCW_RUN: begin
          state_q <= rcw_pkg::RCW_RUN;
        end
        default: begin
          state_q <= rcw_pkg::RCW_RESET;
        end
      endcase
    end
  end

  // warm-up counter
  always_ff @(posedge aclk) begin
    if (any_rst || state_q == rcw_pkg::RCW_RESET) begin
      wcnt_q <= '0;
    end else if (state_q == rcw_pkg::RCW_WARMUP && !warm_done) begin
      wcnt_q <= wcnt_q + 1'b1;
    end
  end

  // trim load during warm-up, shadow copy catches corruption later
  always_ff @(posedge aclk) begin
    if (state_q == rcw_pkg::RCW_RESET) begin
      trim_q     <= rcw_pkg::TRIM_RESET;
      trim_chk_q <= rcw_pkg::TRIM_RESET;
    end else if (state_q == rcw_pkg::RCW_WARMUP) begin
      trim_q     <= trim_store_data;
      trim_chk_q <= trim_store_data;
    end
  end

  assign trim_store_rd = state_q == rcw_pkg::RCW_WARMUP;

  // voltage detector disable: set by hard resets, written by software through bit 0 of the ctrl register
  always_ff @(posedge aclk) begin
    if (hard_rst) begin
      vdet_dis_q <= 1'b1;
    end else if (ctrl_wr && s_axi_wstrb[0]) begin
      vdet_dis_q <= wdata_q[0];
    end
  end
  assign vdet_disable = vdet_dis_q;

  // core control outputs
  always_comb begin
    core              = '0;
    core.pc           = serial_mode ? rcw_pkg::PC_SERIAL_RESET : rcw_pkg::PC_MCU_RESET;
    core.sp           = rcw_pkg::SP_RESET;
    core.bank_sel     = '0;
    core.master_ie    = 1'b0;
    core.clr_ie       = state_q != rcw_pkg::RCW_RUN;
    core.clr_latch    = state_q != rcw_pkg::RCW_RUN;
    core.hf_osc_en    = 1'b1;
    core.lf_osc_en    = 1'b0;
    core.tg_clear     = state_q != rcw_pkg::RCW_RUN;
    core.wdt_en       = state_q == rcw_pkg::RCW_RUN;
    core.cpu_run      = state_q == rcw_pkg::RCW_RUN;
    core.fetch_vector = (state_q == rcw_pkg::RCW_WARMUP) && warm_done;
  end
  assign sys_reset_n = state_q == rcw_pkg::RCW_RUN;

  // axi4-lite write path
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q         <= 1'b0;
      w_q          <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rcw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (aw_q && w_q) begin
        aw_q         <= 1'b0;
        w_q          <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == rcw_pkg::ADDR_CTRL || awaddr_q == rcw_pkg::ADDR_CLEAR)
                        ? rcw_pkg::RESP_OKAY : rcw_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign ctrl_wr = aw_q && w_q && awaddr_q == rcw_pkg::ADDR_CTRL;
  assign clear_hit = aw_q && w_q && awaddr_q == rcw_pkg::ADDR_CLEAR;

  // cause flags: bit 0 of clear arms, key 0x71 then clears
  always_ff @(posedge aclk) begin
    if (hard_rst) begin
      cause_q      <= '0;
      clear_pend_q <= 1'b0;
    end else begin
      if (clear_hit && s_axi_wstrb[0] && wdata_q == rcw_pkg::CLEAR_KEY && clear_pend_q) begin
        cause_q      <= '0;
        clear_pend_q <= 1'b0;
      end else if (clear_hit && s_axi_wstrb[0]) begin
        clear_pend_q <= wdata_q[0];
      end
      if (state_q == rcw_pkg::RCW_RUN) begin
        if (factors.wdt_ovf)     cause_q[rcw_pkg::CB_WDT]  <= 1'b1;
        if (factors.sysclk_dead) cause_q[rcw_pkg::CB_SYS]  <= 1'b1;
        if (factors.lvd1)        cause_q[rcw_pkg::CB_LVD1] <= 1'b1;
        if (factors.lvd2)        cause_q[rcw_pkg::CB_LVD2] <= 1'b1;
        if (trim_corrupt)        cause_q[rcw_pkg::CB_TRMR] <= 1'b1;
      end
      if (state_q == rcw_pkg::RCW_WARMUP && trim_store_bad) begin
        cause_q[rcw_pkg::CB_TRIM_DATA_FAULT_STATUS] <= 1'b1;
      end
    end
  end

  // axi4-lite read path
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= rcw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= rcw_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        rcw_pkg::ADDR_STATUS: s_axi_rdata <= {29'h0, state_q};
        rcw_pkg::ADDR_CAUSE:  s_axi_rdata <= {26'h0, cause_q};
        rcw_pkg::ADDR_CLEAR:  s_axi_rdata <= {31'h0, clear_pend_q};
        rcw_pkg::ADDR_TRIM:   s_axi_rdata <= {24'h0, trim_q};
        rcw_pkg::ADDR_CTRL:   s_axi_rdata <= {31'h0, vdet_dis_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= rcw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  chk_run_gates_wdt: assert property (@(posedge aclk) disable iff (!aresetn)
    core.cpu_run |-> core.wdt_en && !core.tg_clear) else $error("run without watchdog");
  chk_warm_length: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(core.cpu_run) |-> $past(state_q) == rcw_pkg::RCW_WARMUP && $past(warm_done))
    else $error("run entered early");
  chk_reset_stops_run: assert property (@(posedge aclk) disable iff (!aresetn)
    any_rst |=> !core.cpu_run) else $error("run during reset");
  chk_restart_count: assert property (@(posedge aclk) disable iff (!aresetn)
    any_rst |=> wcnt_q == '0) else $error("counter not cleared");
  chk_pc_vector: assert property (@(posedge aclk) disable iff (!aresetn)
    !serial_mode |-> core.pc == rcw_pkg::PC_MCU_RESET) else $error("bad pc");
  chk_hard_vdet: assert property (@(posedge aclk) disable iff (!aresetn)
    hard_rst |=> vdet_disable) else $error("detector not disabled");
  chk_cause_keep: assert property (@(posedge aclk) disable iff (!aresetn)
    factor_rst && !hard_rst |=> cause_q != '0) else $error("cause lost");
  chk_trim_load: assert property (@(posedge aclk) disable iff (!aresetn)
    state_q == rcw_pkg::RCW_WARMUP && !any_rst |=> trim_q == $past(trim_store_data))
    else $error("trim not latched");
  chk_osc_state: assert property (@(posedge aclk) disable iff (!aresetn)
    !core.cpu_run |-> core.hf_osc_en && !core.lf_osc_en) else $error("oscillator state");
  cov_warm_done: cover property (@(posedge aclk) $rose(core.cpu_run));
  cov_factor: cover property (@(posedge aclk) factor_rst);
  cov_pin_reset: cover property (@(posedge aclk) $rose(ext_rst_q));
  cov_trim_fault: cover property (@(posedge aclk) $rose(cause_q[rcw_pkg::CB_TRIM_DATA_FAULT_STATUS]));

endmodule : rcw_top

`default_nettype wire

// file: rcw_pkg.sv
// shared constants and types for the reset and warm-up controller
package rcw_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned PIN_LOW_MIN_NS = 5000;
  localparam int unsigned PIN_LOW_CYCLES = (PIN_LOW_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned WARMUP_DEFAULT = 8192;
  localparam int unsigned WCNT_W = 16;
  localparam int unsigned FCNT_W = 8;

  localparam logic [15:0] PC_MCU_RESET = 16'hfffe;
  localparam logic [15:0] PC_SERIAL_RESET = 16'h1ffe;
  localparam logic [15:0] SP_RESET = 16'h00ff;
  localparam logic [7:0] TRIM_RESET = 8'h00;

  // axi-lite register byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CAUSE = 8'h04;
  localparam logic [7:0] ADDR_CLEAR = 8'h08;
  localparam logic [7:0] ADDR_TRIM = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [31:0] CLEAR_KEY = 32'h00000071;

  // cause register bit positions
  localparam int unsigned CB_WDT = 0;
  localparam int unsigned CB_SYS = 1;
  localparam int unsigned CB_LVD1 = 2;
  localparam int unsigned CB_LVD2 = 3;
  localparam int unsigned CB_TRMR = 4;
  localparam int unsigned CB_TRIM_DATA_FAULT_STATUS = 5;
  localparam int unsigned NCAUSE = 6;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    RCW_RESET  = 3'b001,
    RCW_WARMUP = 3'b010,
    RCW_RUN    = 3'b100
  } rcw_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [1:0]  bank_sel;
    logic        master_ie;
    logic        clr_ie;
    logic        clr_latch;
    logic        hf_osc_en;
    logic        lf_osc_en;
    logic        tg_clear;
    logic        wdt_en;
    logic        cpu_run;
    logic        fetch_vector;
  } rcw_core_t;

  typedef struct packed {
    logic wdt_ovf;
    logic sysclk_dead;
    logic lvd1;
    logic lvd2;
  } rcw_factor_t;
endpackage : rcw_pkg

// file: rcw_pin_src.sv
// external reset source model driving the shared reset pin
`timescale 1ns/10ps
`default_nettype none
module rcw_pin_src (
  input  wire logic aclk,
  output var logic  pin
);
  // pin rests high through its pull-up
  initial pin = 1'b1;

  // hold the pin low for n cycles, then release it
  task automatic pulse(input int n);
    @(posedge aclk);
    pin <= 1'b0;
    repeat (n) @(posedge aclk);
    pin <= 1'b1;
  endtask : pulse
endmodule : rcw_pin_src
`default_nettype wire

// file: rcw_top_test.sv
// self-checking testbench for the reset and warm-up controller
`timescale 1ns/10ps
`default_nettype none
module rcw_top_test;
  localparam int unsigned WU = 16;
  logic                 aclk, aresetn, por_n, pin, serial_mode, trim_store_bad, trim_store_rd;
  logic                 vdet_disable, sys_reset_n;
  rcw_pkg::rcw_factor_t factors;
  rcw_pkg::rcw_core_t   core;
  logic [7:0]           trim_store_data, s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                 s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0]          d;
  logic [1:0]           r;
  int                   n_mismatch, comparisons;

  rcw_top #(.WARMUP_CYCLES(WU)) rcw_top_inst (
    .aclk, .aresetn, .por_n, .shared_port_pin(pin), .serial_mode, .factors, .trim_store_data,
    .trim_store_bad, .trim_store_rd, .core, .vdet_disable, .sys_reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  rcw_pin_src rcw_pin_src_inst (.aclk, .pin);

  always #12.5 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid & s_axi_bready;
      rs = s_axi_bresp;
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid & s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // core outputs while held in reset or warm-up
  task automatic chk_hold(input logic ser);
    chk("pc", 32'(ser ? rcw_pkg::PC_SERIAL_RESET : rcw_pkg::PC_MCU_RESET), 32'(core.pc));
    chk("sp", 32'(rcw_pkg::SP_RESET), 32'(core.sp));
    chk("bank", 32'h0, 32'(core.bank_sel));
    chk("ime", 32'h3, 32'({core.master_ie, core.clr_ie, core.clr_latch}));
    chk("osc", 32'h2, 32'({core.hf_osc_en, core.lf_osc_en}));
    chk("tg clear", 32'h1, 32'(core.tg_clear));
    chk("held", 32'h0, 32'({core.wdt_en, core.cpu_run, sys_reset_n}));
  endtask : chk_hold

  // wait for reset entry, check the hold, then count warm-up to run
  task automatic boot(input logic ser, input logic vd);
    int n, wu, fv;
    n = 0;
    wu = 0;
    fv = 0;
    while (sys_reset_n !== 1'b0 && n < 300) begin
      @(negedge aclk);
      n++;
    end
    chk_hold(ser);
    while (sys_reset_n !== 1'b1 && n < 2000) begin
      @(negedge aclk);
      if (trim_store_rd === 1'b1) wu++;
      if (core.fetch_vector === 1'b1) fv++;
      if (sys_reset_n !== 1'b1) chk_hold(ser);
      n++;
    end
    chk("warmup", 32'(WU), 32'(wu));
    chk("fetch vector", 32'h1, 32'(fv));
    chk("vdet", 32'(vd), 32'(vdet_disable));
    chk("run", 32'h3, 32'({core.wdt_en, core.cpu_run}));
  endtask : boot

  task automatic factor_resets();
    logic [31:0] exp;
    exp = 32'h0;
    axi_wr(rcw_pkg::ADDR_CTRL, 32'h0, r);
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      factors <= rcw_pkg::rcw_factor_t'(4'b1000 >> i);
      trim_store_bad <= (i == 1);
      @(posedge aclk);
      factors <= '0;
      boot(1'b0, 1'b0);
      trim_store_bad <= 1'b0;
      exp = exp | (32'h1 << i) | ((i == 1) ? 32'h20 : 32'h0);
      axi_rd(rcw_pkg::ADDR_CAUSE, d, r);
      chk("cause", exp, d);
    end
  endtask : factor_resets

  task automatic clear_and_bus();
    axi_wr(rcw_pkg::ADDR_CLEAR, 32'h1, r);
    axi_wr(rcw_pkg::ADDR_CLEAR, rcw_pkg::CLEAR_KEY, r);
    chk("bresp", 32'(rcw_pkg::RESP_OKAY), 32'(r));
    axi_rd(rcw_pkg::ADDR_CAUSE, d, r);
    chk("cause clr", 32'h0, d);
    axi_rd(8'h20, d, r);
    chk("unmapped", {30'h0, rcw_pkg::RESP_SLVERR}, {d[29:0], r});
    axi_rd(rcw_pkg::ADDR_STATUS, d, r);
    chk("status", 32'(rcw_pkg::RCW_RUN), d);
  endtask : clear_and_bus

  task automatic pin_and_por();
    rcw_pin_src_inst.pulse(rcw_pkg::PIN_LOW_CYCLES / 2);
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk("short pin", 32'h1, 32'(sys_reset_n));
    serial_mode <= 1'b1;
    fork
      rcw_pin_src_inst.pulse(rcw_pkg::PIN_LOW_CYCLES + 4);
      boot(1'b1, 1'b1);
    join
    axi_rd(rcw_pkg::ADDR_TRIM, d, r);
    chk("trim", 32'h5a, d);
    serial_mode <= 1'b0;
    axi_wr(rcw_pkg::ADDR_CTRL, 32'h0, r);
    por_n <= 1'b0;
    repeat (5) @(posedge aclk);
    por_n <= 1'b1;
    boot(1'b0, 1'b1);
  endtask : pin_and_por

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    por_n = 1'b1;
    serial_mode = 1'b0;
    factors = '0;
    trim_store_data = 8'h5a;
    trim_store_bad = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    n_mismatch = 0;
    comparisons = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    boot(1'b0, 1'b1);
    factor_resets();
    clear_and_bus();
    pin_and_por();
    results();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end
endmodule : rcw_top_test
`default_nettype wire
